// ==== rtl/pmc_pkg.sv ====
// Shared constants and types for the power-management control block
package pmc_pkg;

   // Register addresses (7-bit serial address space)
   localparam logic [6:0] ADDR_ID      = 7'h00;
   localparam logic [6:0] ADDR_ENABLE  = 7'h01;
   localparam logic [6:0] ADDR_INT     = 7'h0C;
   localparam logic [6:0] ADDR_MASK    = 7'h0D;
   localparam logic [6:0] ADDR_KEY     = 7'h10;
   localparam logic [6:0] ADDR_SYS     = 7'h11;
   localparam logic [6:0] ADDR_USER    = 7'h20;
   localparam logic [6:0] ADDR_PROT_LO = 7'h11;
   localparam logic [6:0] ADDR_PROT_HI = 7'h27;

   // Command byte layout
   localparam int CMD_WRITE_BIT = 7;

   // Enable register fields and reset
   localparam int         EN_MIRROR_BIT = 1;
   localparam int         EN_LED_BIT    = 0;
   localparam logic [1:0] ENABLE_RST    = 2'h3;

   // Other reset values
   localparam logic [5:0] MASK_RST = 6'h00;
   localparam logic [7:0] SYS_RST  = 8'h00;
   localparam logic [7:0] USER_RST = 8'h00;

   // Unlock key values and key register read-back
   localparam logic [7:0] KEY_FIRST  = 8'hBA;
   localparam logic [7:0] KEY_SECOND = 8'hBE;
   localparam logic [7:0] KEY_LOCKED = 8'h00;
   localparam logic [7:0] KEY_OPEN   = 8'h01;

   // Event flag positions in the interrupt flag and mask registers
   localparam int EV_BAT    = 0;
   localparam int EV_UNDERVOLTAGE_LOCKOUT_FLAG   = 1;
   localparam int EV_MIRROR = 2;
   localparam int EV_AUX    = 3;
   localparam int EV_OVP    = 4;
   localparam int EV_TSD    = 5;
   localparam int NUM_EV    = 6;

   // Timing: re-assertion of a persisting interrupt, longest time rounds down
   localparam int CLK_NS      = 100;
   localparam int PERSIST_NS  = 32000;
   localparam int PERSIST_CYC = PERSIST_NS / CLK_NS;

   // Operating modes, Gray coded along off, standby, supplies, full run
   typedef enum logic [2:0] {
      MODE_OFF      = 3'b000,
      MODE_STANDBY  = 3'b001,
      MODE_SUPPLIES = 3'b011,
      MODE_FULL     = 3'b010,
      MODE_RESET    = 3'b100
   } pmc_mode_t;

endpackage

// ==== rtl/pmc_link_if.sv ====
// Byte hand-off between the serial engine and the register core
`timescale 1ns/1ps
interface pmc_link_if;
   logic       byte_done;
   logic       first;
   logic [7:0] rx_byte;
   logic [7:0] tx_byte;

   modport engine (output byte_done, output first, output rx_byte, input tx_byte);
   modport core   (input byte_done, input first, input rx_byte, output tx_byte);
endinterface

// ==== rtl/pmc_sync.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pmc_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Data
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] st1;
   logic [WIDTH-1:0] st2;
   logic [WIDTH-1:0] st3;

   // A change is taken only when stages two and three agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st1  <= RST_VAL;
         st2  <= RST_VAL;
         st3  <= RST_VAL;
         dout <= RST_VAL;
      end else begin
         st1 <= din;
         st2 <= st1;
         st3 <= st2;
         for (int i = 0; i < WIDTH; i++) begin
            if (st2[i] == st3[i]) begin
               dout[i] <= st3[i];
            end
         end
      end
   end
endmodule // pmc_sync

// ==== rtl/pmc_spi.sv ====
// Serial port engine: oversampled clock, byte assembly and read shifter
`timescale 1ns/1ps
module pmc_spi (
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  rst,
   // Synchronised serial pins
   input  wire logic  sclk_s,
   input  wire logic  csn_s,
   input  wire logic  din_s,
   // Byte link to the core
   pmc_link_if.engine lk,
   // Serial output pin
   output logic       spi_dout,
   output logic       spi_dout_oe
);
   logic       sclk_d;
   logic [2:0] bit_cnt;
   logic [7:0] rx_sh;
   logic [7:0] tx_sh;

   wire rise      = sclk_s & ~sclk_d & ~csn_s;
   wire fall      = ~sclk_s & sclk_d & ~csn_s;
   wire rise_last = rise & (bit_cnt == 3'h7);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_d       <= 1'b0;
         bit_cnt      <= 3'h0;
         rx_sh        <= 8'h00;
         lk.byte_done <= 1'b0;
         lk.rx_byte   <= 8'h00;
      end else begin
         sclk_d       <= sclk_s;
         lk.byte_done <= rise_last;
         if (csn_s) begin
            bit_cnt <= 3'h0;
         end else if (rise) begin
            bit_cnt <= 3'(bit_cnt + 3'h1);
            rx_sh   <= {rx_sh[6:0], din_s};
         end
         if (rise_last) begin
            lk.rx_byte <= {rx_sh[6:0], din_s};
         end
      end
   end

   // Cleared once the command byte has been handed over
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lk.first <= 1'b1;
      end else if (csn_s) begin
         lk.first <= 1'b1;
      end else if (lk.byte_done) begin
         lk.first <= 1'b0;
      end
   end

   // Output changes on falling edges; a new byte loads after each boundary
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         spi_dout    <= 1'b0;
         spi_dout_oe <= 1'b0;
         tx_sh       <= 8'h00;
      end else begin
         spi_dout_oe <= ~csn_s;
         if (fall && bit_cnt == 3'h0) begin
            spi_dout <= lk.tx_byte[7];
            tx_sh    <= {lk.tx_byte[6:0], 1'b0};
         end else if (fall) begin
            spi_dout <= tx_sh[7];
            tx_sh    <= {tx_sh[6:0], 1'b0};
         end
      end
   end

   a_cs_quiet: assert property (@(posedge clk) disable iff (rst)
      csn_s |=> !spi_dout_oe && !lk.byte_done)
      else $error("serial output active while deselected");

   a_rise_sample: assert property (@(posedge clk) disable iff (rst)
      rise_last |=> lk.byte_done && lk.rx_byte[0] == $past(din_s))
      else $error("last bit not taken on rising edge");
endmodule // pmc_spi

// ==== rtl/pmc_top.sv ====
// Power-management control core: serial registers, faults, interrupt, modes
`timescale 1ns/1ps
module pmc_top #(
   parameter logic [7:0] CHIP_ID        = 8'h5A, // Arbitrary identification value
   parameter int         PERSIST_CYCLES = pmc_pkg::PERSIST_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Serial port
   input  wire logic spi_clk,
   input  wire logic chip_select_n,
   input  wire logic spi_din,
   output logic      spi_dout,
   output logic      spi_dout_oe,
   // Power-on pin and monitor comparators
   input  wire logic power_on_request_pin,
   input  wire logic battery_low_cmp,
   input  wire logic undervoltage_cmp,
   input  wire logic input_recovered,
   input  wire logic mirror_reg_fault,
   input  wire logic aux_power_good,
   input  wire logic led_overvoltage_cmp,
   input  wire logic thermal_shutdown_cmp,
   // Open-drain interrupt
   output logic      interrupt_out_n_o,
   output logic      interrupt_out_n_oe,
   // Power control
   output logic      system_reset_out_n,
   output logic      power_enable_out,
   output logic      mirror_supply_on,
   output logic      led_rail_on,
   output logic      strobe_decoder_on
);
   localparam int NIN      = 11;
   localparam int PCW      = $clog2(PERSIST_CYCLES + 1);
   localparam int PERSIST_A = PERSIST_CYCLES + 2;
   // Idle levels: deselected and power good, so no false event follows reset
   localparam logic [NIN-1:0] SYNC_RST = 11'h104;

   // Input synchronisation
   logic [NIN-1:0] raw;
   logic [NIN-1:0] lvl;
   assign raw = {thermal_shutdown_cmp, led_overvoltage_cmp, aux_power_good, mirror_reg_fault,
                 input_recovered, undervoltage_cmp, battery_low_cmp, power_on_request_pin,
                 chip_select_n, spi_din, spi_clk};

   pmc_sync #(.WIDTH(NIN), .RST_VAL(SYNC_RST)) u_sync (
      .clk  (clk),
      .rst  (rst),
      .din  (raw),
      .dout (lvl)
   );

   wire sclk_s   = lvl[0];
   wire din_s    = lvl[1];
   wire csn_s    = lvl[2];
   wire pin_s    = lvl[3];
   wire bat_s    = lvl[4];
   wire undervoltage_lockout_flag_s   = lvl[5];
   wire recov_s  = lvl[6];
   wire mflt_s   = lvl[7];
   wire auxpg_s  = lvl[8];
   wire ovp_s    = lvl[9];
   wire tsd_s    = lvl[10];

   // Serial engine
   pmc_link_if lk ();

   pmc_spi u_spi (
      .clk         (clk),
      .rst         (rst),
      .sclk_s      (sclk_s),
      .csn_s       (csn_s),
      .din_s       (din_s),
      .lk          (lk.engine),
      .spi_dout    (spi_dout),
      .spi_dout_oe (spi_dout_oe)
   );

   // State
   pmc_pkg::pmc_mode_t mode;
   pmc_pkg::pmc_mode_t next_mode;
   logic [pmc_pkg::NUM_EV-1:0] cond_d;
   logic [pmc_pkg::NUM_EV-1:0] flags;
   logic [pmc_pkg::NUM_EV-1:0] mask;
   logic       mirror_en;
   logic       led_en;
   logic [6:0] ptr;
   logic       wr_mode;
   logic       int_pending;
   logic       key_armed;
   logic       unlocked;
   logic       released;
   logic [7:0] sys_reg;
   logic [7:0] user_mem [8];
   logic [PCW-1:0] pcnt;
   logic [7:0] rd_data;

   // Fault and event detection; each event is the rise of its condition
   wire [pmc_pkg::NUM_EV-1:0] cond = {tsd_s, ovp_s, ~auxpg_s, mflt_s, undervoltage_lockout_flag_s, bat_s};
   wire [pmc_pkg::NUM_EV-1:0] ev   = cond & ~cond_d;

   // Off and reset modes hold registers at default, except that reset mode clears mirror enable, and ignore the port
   wire in_off    = (mode == pmc_pkg::MODE_OFF);
   wire in_reset  = (mode == pmc_pkg::MODE_RESET);
   wire soft_clr  = in_off | in_reset;
   wire serial_ok = ~soft_clr;

   // Command and data byte decode
   wire       take      = lk.byte_done & serial_ok;
   wire       take_cmd  = take & lk.first;
   wire       take_data = take & ~lk.first;
   wire       cmd_write = lk.rx_byte[pmc_pkg::CMD_WRITE_BIT];
   wire [6:0] cmd_addr  = lk.rx_byte[6:0];
   wire       do_write  = take_data & wr_mode;
   wire       do_read   = (take_cmd & ~cmd_write) | (take_data & ~wr_mode);
   wire [6:0] rd_addr   = take_cmd ? cmd_addr : ptr;
   wire [6:0] next_ptr  = 7'(rd_addr + 7'h01);
   wire       prot      = (ptr >= pmc_pkg::ADDR_PROT_LO) && (ptr <= pmc_pkg::ADDR_PROT_HI);
   wire       wr_ok     = do_write & (~prot | unlocked);
   wire       wr_enable = wr_ok && ptr == pmc_pkg::ADDR_ENABLE;
   wire       wr_mask   = wr_ok && ptr == pmc_pkg::ADDR_MASK;
   wire       wr_key    = do_write && ptr == pmc_pkg::ADDR_KEY;
   wire       wr_sys    = wr_ok && ptr == pmc_pkg::ADDR_SYS;
   wire       wr_user   = wr_ok && ptr[6:3] == pmc_pkg::ADDR_USER[6:3];
   // Flag clear is committed only once the flag byte has fully shifted out
   wire       rd_clr    = int_pending & take_data;

   // Read selection
   always_comb begin
      case (rd_addr)
         pmc_pkg::ADDR_ID:     rd_data = CHIP_ID;
         pmc_pkg::ADDR_ENABLE: rd_data = {6'h00, mirror_en, led_en};
         pmc_pkg::ADDR_INT:    rd_data = {2'h0, flags};
         pmc_pkg::ADDR_MASK:   rd_data = {2'h0, mask};
         pmc_pkg::ADDR_KEY:    rd_data = unlocked ? pmc_pkg::KEY_OPEN : pmc_pkg::KEY_LOCKED;
         pmc_pkg::ADDR_SYS:    rd_data = sys_reg;
         default:              rd_data = (rd_addr[6:3] == pmc_pkg::ADDR_USER[6:3]) ?
                                         user_mem[rd_addr[2:0]] : 8'h00;
      endcase
   end

   // Flags: set wins over clear; a still-present condition keeps its flag
   wire [pmc_pkg::NUM_EV-1:0] next_flags =
      (((rd_clr | soft_clr) ? (flags & cond) : flags)) | ev;

   // Periodic re-fire tick for persisting faults
   wire tick = (pcnt == PCW'(PERSIST_CYCLES - 1));
   wire new_irq = |(ev & ~mask);
   wire next_released = (released | rd_clr) & ~(new_irq | tick);
   wire next_irq = |(next_flags & ~mask) & ~next_released;

   // Mode selection
   always_comb begin
      if (!pin_s) begin
         next_mode = pmc_pkg::MODE_OFF;
      end else if (undervoltage_lockout_flag_s) begin
         next_mode = pmc_pkg::MODE_RESET;
      end else if (!mirror_en || tsd_s || mflt_s || !recov_s) begin
         next_mode = pmc_pkg::MODE_STANDBY;
      end else if (led_en) begin
         next_mode = pmc_pkg::MODE_FULL;
      end else begin
         next_mode = pmc_pkg::MODE_SUPPLIES;
      end
   end

   wire rails_up = (next_mode == pmc_pkg::MODE_SUPPLIES) || (next_mode == pmc_pkg::MODE_FULL);
   // LED rail drops on aux power-good loss and comes back on its own
   wire led_up = (next_mode == pmc_pkg::MODE_FULL) && auxpg_s;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode   <= pmc_pkg::MODE_OFF;
         cond_d <= '0;
         flags  <= '0;
         pcnt   <= '0;
      end else begin
         mode   <= next_mode;
         cond_d <= cond;
         flags  <= next_flags;
         pcnt   <= tick ? '0 : PCW'(pcnt + 1'b1);
      end
   end

   // Power outputs and interrupt pin, all registered
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         released           <= 1'b0;
         interrupt_out_n_o  <= 1'b0;
         interrupt_out_n_oe <= 1'b0;
         system_reset_out_n <= 1'b0;
         power_enable_out   <= 1'b0;
         mirror_supply_on   <= 1'b0;
         led_rail_on        <= 1'b0;
         strobe_decoder_on  <= 1'b0;
      end else begin
         released           <= next_released;
         interrupt_out_n_o  <= 1'b0;
         interrupt_out_n_oe <= next_irq;
         system_reset_out_n <= ~(next_mode == pmc_pkg::MODE_OFF || next_mode == pmc_pkg::MODE_RESET);
         power_enable_out   <= ~(next_mode == pmc_pkg::MODE_OFF || next_mode == pmc_pkg::MODE_RESET);
         mirror_supply_on   <= rails_up;
         led_rail_on        <= led_up;
         strobe_decoder_on  <= led_up;
      end
   end

   // Enable register; the mirror bit can be cleared by writes but only set by a pin toggle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mirror_en <= pmc_pkg::ENABLE_RST[pmc_pkg::EN_MIRROR_BIT];
         led_en    <= pmc_pkg::ENABLE_RST[pmc_pkg::EN_LED_BIT];
      end else if (in_off) begin
         mirror_en <= pmc_pkg::ENABLE_RST[pmc_pkg::EN_MIRROR_BIT];
         led_en    <= pmc_pkg::ENABLE_RST[pmc_pkg::EN_LED_BIT];
      end else if (in_reset || ev[pmc_pkg::EV_UNDERVOLTAGE_LOCKOUT_FLAG] || ev[pmc_pkg::EV_MIRROR]) begin
         mirror_en <= 1'b0;
         led_en    <= in_reset ? pmc_pkg::ENABLE_RST[pmc_pkg::EN_LED_BIT] : led_en;
      end else if (wr_enable) begin
         mirror_en <= mirror_en & lk.rx_byte[pmc_pkg::EN_MIRROR_BIT];
         led_en    <= lk.rx_byte[pmc_pkg::EN_LED_BIT];
      end
   end

   // Serial pointer, direction and flag-read bookkeeping
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ptr         <= 7'h00;
         wr_mode     <= 1'b0;
         int_pending <= 1'b0;
         lk.tx_byte  <= 8'h00;
      end else begin
         if (take_cmd) begin
            wr_mode <= cmd_write;
            ptr     <= cmd_write ? cmd_addr : next_ptr;
         end else if (take_data) begin
            ptr     <= next_ptr;
         end
         if (do_read) begin
            lk.tx_byte <= rd_data;
         end
         if (csn_s || do_read || take_data) begin
            int_pending <= do_read && rd_addr == pmc_pkg::ADDR_INT;
         end
      end
   end

   // Key sequence; any data byte between the two key writes disarms it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         key_armed <= 1'b0;
         unlocked  <= 1'b0;
      end else if (soft_clr) begin
         key_armed <= 1'b0;
         unlocked  <= 1'b0;
      end else begin
         if (take_data) begin
            key_armed <= wr_key && lk.rx_byte == pmc_pkg::KEY_FIRST;
         end
         if (wr_key) begin
            unlocked <= (key_armed && lk.rx_byte == pmc_pkg::KEY_SECOND) ||
                        (unlocked && lk.rx_byte == pmc_pkg::KEY_FIRST);
         end
      end
   end

   // Mask, system and user bytes; protected writes land only when unlocked
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mask    <= pmc_pkg::MASK_RST;
         sys_reg <= pmc_pkg::SYS_RST;
         for (int i = 0; i < 8; i++) user_mem[i] <= pmc_pkg::USER_RST;
      end else if (soft_clr) begin
         mask    <= pmc_pkg::MASK_RST;
         sys_reg <= pmc_pkg::SYS_RST;
         for (int i = 0; i < 8; i++) user_mem[i] <= pmc_pkg::USER_RST;
      end else begin
         if (wr_mask) mask <= lk.rx_byte[pmc_pkg::NUM_EV-1:0];
         if (wr_sys) sys_reg <= lk.rx_byte;
         if (wr_user) user_mem[ptr[2:0]] <= lk.rx_byte;
      end
   end

   sequence s_mirror_fault;
      ev[pmc_pkg::EV_MIRROR] && pin_s && !undervoltage_lockout_flag_s;
   endsequence

   sequence s_read_persist;
      rd_clr && |(flags & cond & ~mask) && pin_s && !undervoltage_lockout_flag_s;
   endsequence

   a_battery_flag: assert property (@(posedge clk) disable iff (rst)
      ev[pmc_pkg::EV_BAT] && !ev[pmc_pkg::EV_UNDERVOLTAGE_LOCKOUT_FLAG] && !ev[pmc_pkg::EV_MIRROR] && pin_s
      |=> flags[pmc_pkg::EV_BAT] && mirror_en == $past(mirror_en))
      else $error("battery-low flag missing or enable disturbed");

   a_lockout_drop: assert property (@(posedge clk) disable iff (rst)
      ev[pmc_pkg::EV_UNDERVOLTAGE_LOCKOUT_FLAG] && pin_s |=> !mirror_en && flags[pmc_pkg::EV_UNDERVOLTAGE_LOCKOUT_FLAG])
      else $error("lockout did not clear mirror enable");

   a_mirror_fault: assert property (@(posedge clk) disable iff (rst)
      s_mirror_fault |=> !mirror_en ##1 !mirror_supply_on)
      else $error("mirror fault did not shut supply");

   a_led_follows: assert property (@(posedge clk) disable iff (rst)
      !mirror_en |=> !led_rail_on && !strobe_decoder_on)
      else $error("LED path on with mirror enable clear");

   a_irq_pull: assert property (@(posedge clk) disable iff (rst)
      |(ev & ~mask) |=> interrupt_out_n_oe)
      else $error("unmasked event did not pull interrupt");

   a_read_release: assert property (@(posedge clk) disable iff (rst)
      rd_clr && !new_irq && !tick |=> !interrupt_out_n_oe)
      else $error("flag read did not release interrupt");

   a_persist_refire: assert property (@(posedge clk) disable iff (rst)
      s_read_persist |-> ##[1:PERSIST_A] (interrupt_out_n_oe || !(|(cond & ~mask))))
      else $error("persisting fault did not re-pull interrupt");

   a_mask_gate: assert property (@(posedge clk) disable iff (rst)
      !interrupt_out_n_oe && !new_irq && !tick && (ev != '0) |=> !interrupt_out_n_oe && (flags & $past(ev)) == $past(ev))
      else $error("masked event misbehaved");

   a_ptr_wrap: assert property (@(posedge clk) disable iff (rst)
      take_data && ptr == 7'h7F |=> ptr == 7'h00)
      else $error("address pointer did not wrap");

   a_off_mode: assert property (@(posedge clk) disable iff (rst)
      !pin_s |=> in_off && !power_enable_out && !system_reset_out_n)
      else $error("off mode not entered with pin low");

   a_locked_write: assert property (@(posedge clk) disable iff (rst)
      do_write && !unlocked && ptr == pmc_pkg::ADDR_SYS |=> $stable(sys_reg))
      else $error("protected register written while locked");
endmodule // pmc_top

// ==== testbench/pmc_host.sv ====
// Serial host model that drives the register port
`timescale 1ns/1ps
module pmc_host (
   // Serial pins
   output logic      spi_clk,
   output logic      chip_select_n,
   output logic      spi_din,
   input  wire logic spi_dout
);
   initial begin
      spi_clk = 1'h0;
      chip_select_n = 1'h1;
      spi_din = 1'h0;
   end
   // Up to three bytes, MSB first; the clock stands low between frames
   task automatic xfer(input int n, input logic [23:0] tx, output logic [23:0] rx);
      chip_select_n = 1'h0;
      #800;
      for (int i = 0; i < 8 * n; i++) begin
         spi_din = tx[23 - i];
         #400 spi_clk = 1'h1;
         // Taken late in the high phase: the synchronised output lags the falling edge
         #400 rx = {rx[22:0], spi_dout};
         spi_clk = 1'h0;
      end
      #800 chip_select_n = 1'h1;
      // Released line must not keep its last value
      spi_din = ~spi_din;
      #800;
   endtask
endmodule // pmc_host

// ==== testbench/test_pmc_top.sv ====
// Self-checking bench for the power-management control core
`timescale 1ns/1ps
module test_pmc_top;
   localparam logic [7:0] ID = 8'hC3; // Arbitrary identification value
   logic clk, rst, spi_clk, chip_select_n, spi_din, spi_dout, spi_dout_oe;
   logic power_on_request_pin, battery_low_cmp, undervoltage_cmp, input_recovered;
   logic mirror_reg_fault, aux_power_good, led_overvoltage_cmp, thermal_shutdown_cmp;
   logic interrupt_out_n_o, interrupt_out_n_oe, system_reset_out_n, power_enable_out;
   logic mirror_supply_on, led_rail_on, strobe_decoder_on;
   logic [23:0] rx;
   int num_errors = 0;
   int tests_run = 0;
   typedef struct {logic [6:0] a; logic [7:0] w; logic [7:0] e;} pmc_row_t;
   pmc_row_t rows [4] = '{'{pmc_pkg::ADDR_MASK, 8'hEA, 8'h2A}, '{pmc_pkg::ADDR_SYS, 8'h77, 8'h00},
      '{pmc_pkg::ADDR_ID, 8'hFF, ID}, '{pmc_pkg::ADDR_USER, 8'h42, 8'h00}};

   pmc_top #(.CHIP_ID(ID), .PERSIST_CYCLES(8)) i_pmc_top (.clk, .rst, .spi_clk,
      .chip_select_n, .spi_din, .spi_dout, .spi_dout_oe, .power_on_request_pin,
      .battery_low_cmp, .undervoltage_cmp, .input_recovered, .mirror_reg_fault,
      .aux_power_good, .led_overvoltage_cmp, .thermal_shutdown_cmp, .interrupt_out_n_o,
      .interrupt_out_n_oe, .system_reset_out_n, .power_enable_out, .mirror_supply_on,
      .led_rail_on, .strobe_decoder_on);
   pmc_host i_pmc_host (.spi_clk, .chip_select_n, .spi_din, .spi_dout);

   task automatic chk8(input string s, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic chk1(input string s, input logic e, input logic g);
      chk8(s, {7'h00, e}, {7'h00, g});
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      i_pmc_host.xfer(2, {1'h1, a, d, 8'h00}, rx);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      @(posedge clk);
      #1;
      i_pmc_host.xfer(2, {1'h0, a, 16'h0000}, rx);
      chk8("read", e, rx[7:0]);
   endtask
   // Bounded wait keeps a stuck pin from hanging the run
   task automatic wait_oe(input logic e);
      for (int i = 0; i < 40 && interrupt_out_n_oe !== e; i++) begin
         @(posedge clk);
         #1;
      end
      chk1("int_oe", e, interrupt_out_n_oe);
   endtask
   task automatic close_out;
      $display("Comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   initial begin
      #3000000 num_errors++;
      close_out;
   end
   initial begin
      {rst, power_on_request_pin, input_recovered, aux_power_good} = 4'hF;
      {battery_low_cmp, undervoltage_cmp, mirror_reg_fault} = 3'h0;
      {led_overvoltage_cmp, thermal_shutdown_cmp} = 2'h0;
      repeat (10) @(posedge clk);
      #1 rst = 1'h0;
      repeat (10) @(posedge clk);
      chk1("mirror_on", 1'h1, mirror_supply_on);
      chk1("strobe_on", 1'h1, strobe_decoder_on);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, rows[i].e);
      end
      chk1("dout_oe", 1'h0, spi_dout_oe);
      rd(pmc_pkg::ADDR_KEY, pmc_pkg::KEY_LOCKED);
      wr(pmc_pkg::ADDR_KEY, pmc_pkg::KEY_FIRST);
      wr(pmc_pkg::ADDR_KEY, pmc_pkg::KEY_SECOND);
      rd(pmc_pkg::ADDR_KEY, pmc_pkg::KEY_OPEN);
      wr(pmc_pkg::ADDR_SYS, 8'hA5);
      rd(pmc_pkg::ADDR_SYS, 8'hA5);
      wr(7'h7F, 8'h00);
      i_pmc_host.xfer(3, 24'h7F0000, rx);
      chk8("wrap", ID, rx[7:0]);
      wr(pmc_pkg::ADDR_KEY, 8'h00);
      rd(pmc_pkg::ADDR_KEY, pmc_pkg::KEY_LOCKED);
      @(posedge clk) #1 battery_low_cmp = 1'h1;
      wait_oe(1'h1);
      chk1("mirror_on", 1'h1, mirror_supply_on);
      rd(pmc_pkg::ADDR_INT, 8'h01);
      wait_oe(1'h1);
      wr(pmc_pkg::ADDR_MASK, 8'h2B);
      rd(pmc_pkg::ADDR_INT, 8'h01);
      wait_oe(1'h0);
      @(posedge clk) #1 battery_low_cmp = 1'h0;
      rd(pmc_pkg::ADDR_INT, 8'h01);
      wait_oe(1'h0);
      rd(pmc_pkg::ADDR_INT, 8'h00);
      wr(pmc_pkg::ADDR_MASK, 8'h10);
      @(posedge clk) #1 led_overvoltage_cmp = 1'h1;
      repeat (10) @(posedge clk);
      chk1("int_oe", 1'h0, interrupt_out_n_oe);
      chk1("led_on", 1'h1, led_rail_on);
      rd(pmc_pkg::ADDR_INT, 8'h10);
      led_overvoltage_cmp = 1'h0;
      mirror_reg_fault = 1'h1;
      repeat (10) @(posedge clk);
      chk1("mirror_on", 1'h0, mirror_supply_on);
      chk1("led_on", 1'h0, led_rail_on);
      chk1("power_enable_out", 1'h1, power_enable_out);
      @(posedge clk) #1 mirror_reg_fault = 1'h0;
      rd(pmc_pkg::ADDR_ENABLE, 8'h01);
      @(posedge clk) #1 undervoltage_cmp = 1'h1;
      repeat (10) @(posedge clk);
      chk1("power_enable_out", 1'h0, power_enable_out);
      @(posedge clk) #1 undervoltage_cmp = 1'h0;
      repeat (10) @(posedge clk);
      chk1("mirror_on", 1'h0, mirror_supply_on);
      @(posedge clk) #1 power_on_request_pin = 1'h0;
      repeat (10) @(posedge clk);
      chk1("reset_n", 1'h0, system_reset_out_n);
      @(posedge clk) #1 power_on_request_pin = 1'h1;
      repeat (10) @(posedge clk);
      chk1("mirror_on", 1'h1, mirror_supply_on);
      rd(pmc_pkg::ADDR_SYS, 8'h00);
      @(posedge clk) #1 aux_power_good = 1'h0;
      repeat (10) @(posedge clk);
      chk1("led_on", 1'h0, led_rail_on);
      chk1("mirror_on", 1'h1, mirror_supply_on);
      @(posedge clk) #1 aux_power_good = 1'h1;
      repeat (10) @(posedge clk);
      chk1("led_on", 1'h1, led_rail_on);
      rd(pmc_pkg::ADDR_INT, 8'h08);
      wr(pmc_pkg::ADDR_ENABLE, 8'h02);
      repeat (4) @(posedge clk);
      chk1("led_on", 1'h0, led_rail_on);
      chk1("strobe_on", 1'h0, strobe_decoder_on);
      chk1("mirror_on", 1'h1, mirror_supply_on);
      @(posedge clk) #1 rst = 1'h1;
      @(posedge clk) #1;
      chk1("power_enable_out", 1'h0, power_enable_out);
      chk1("int_oe", 1'h0, interrupt_out_n_oe);
      rst = 1'h0;
      repeat (10) @(posedge clk);
      rd(pmc_pkg::ADDR_ENABLE, 8'h03);
      chk1("reset_n", 1'h1, system_reset_out_n);
      chk1("int_o", 1'h0, interrupt_out_n_o);
      close_out;
   end
endmodule // test_pmc_top
